// ===== tb/pmx_board_model.sv
module pmx_board_model (
    input  wire pmx_pkg::pmx_pin_drive_type pin_drive,
    input  wire logic [7:0]                 board_val,
    output logic [7:0]                      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Driven pin reads back its own level, released pin follows the board
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            if (pin_drive.oe[p])
                pin_in[p] = pin_drive.out[p];
            else
                pin_in[p] = board_val[p];
        end
    end
endmodule : pmx_board_model

// ===== tb/pmx_checker.sv
module pmx_checker (
    input wire logic                       clock,
    input wire logic                       reset,
    input wire pmx_pkg::pmx_apb_req_type   apb_req,
    input wire pmx_pkg::pmx_apb_rsp_type   apb_rsp,
    input wire logic [7:0]                 pin_in,
    input wire pmx_pkg::pmx_pin_drive_type pin_drive,
    input wire logic                       opt_reset_pin_is_reset,
    input wire logic                       shutdown_mode,
    input wire logic                       external_reset_input_req,
    input wire logic                       wake_request,
    input wire logic                       irq
);
    localparam logic [7:0] KEEP_MASK = pmx_pkg::SHUTDOWN_RETENTION_MASK;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    a_ready_timing: assert property (apb_req.psel && $rose(apb_req.penable) |=> apb_rsp.pready)
        else $error("pready late");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready too long");
    a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    a_reset_req: assert property (!$past(reset) |-> external_reset_input_req ==
        ($past(opt_reset_pin_is_reset) && !$past(pin_in[pmx_pkg::RESET_SHARED_PIN])))
        else $error("reset request wrong");
    a_reset_no_drive: assert property ($past(opt_reset_pin_is_reset) && !$past(reset) |->
        !pin_drive.oe[pmx_pkg::RESET_SHARED_PIN])
        else $error("reset pin driven");
    a_reset_defaults: assert property ($fell(reset) |->
        pin_drive.pull_up == pmx_pkg::PULL_UP_RESET && pin_drive.oe == 8'h00 && !irq)
        else $error("pin defaults wrong");
    a_wake_in_shut: assert property (wake_request |->
        $past(shutdown_mode) && $past(shutdown_mode, 2) ##1 !wake_request)
        else $error("wake outside shutdown");
    a_retention_hold: assert property (shutdown_mode && $past(shutdown_mode) && $past(shutdown_mode, 2)
        && !$past(reset) && !$past(reset, 2)
        |-> (pin_drive.out & KEEP_MASK) == ($past(pin_drive.out) & KEEP_MASK)
        && (pin_drive.oe & KEEP_MASK) == ($past(pin_drive.oe) & KEEP_MASK))
        else $error("retention lost");
    c_wake: cover property (wake_request);
    c_irq: cover property ($rose(irq));
    c_err: cover property (apb_rsp.pslverr);
endmodule : pmx_checker

bind pmx_top pmx_checker u_chk (.clock(clock), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pin_in(pin_in), .pin_drive(pin_drive), .opt_reset_pin_is_reset(opt_reset_pin_is_reset),
    .shutdown_mode(shutdown_mode), .external_reset_input_req(external_reset_input_req),
    .wake_request(wake_request), .irq(irq));

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clock;
    logic                       reset;
    pmx_pkg::pmx_apb_req_type   apb_req;
    pmx_pkg::pmx_apb_rsp_type   apb_rsp;
    pmx_pkg::pmx_pin_drive_type pin_drive;
    logic [7:0]                 pin_in;
    logic [7:0]                 board_val;
    logic [7:0]                 used;
    logic [15:0]                periph_out;
    logic [15:0]                periph_oe;
    logic [15:0]                periph_in;
    logic                       shutdown_mode;
    logic                       opt_reset;
    logic                       ext_req;
    logic                       wake_request;
    logic                       irq;
    logic                       rerr;
    logic [31:0]                rdata;
    logic [31:0]                sel;
    int                         fails;
    int                         checks_done;
    int                         win;
    int                         ws;
    int                         sl;
    int                         n;

    pmx_top DUT (.clock(clock), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in),
        .pin_drive(pin_drive), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
        .shutdown_mode(shutdown_mode), .opt_reset_pin_is_reset(opt_reset),
        .external_reset_input_req(ext_req), .wake_request(wake_request), .irq(irq));
    pmx_board_model board (.pin_drive(pin_drive), .board_val(board_val), .pin_in(pin_in));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic results();
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick

    // One APB transfer: setup, access until pready, release, one idle edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int k;
        apb_req <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        check({31'h0, apb_rsp.pready}, 32'h1, "pready missing");
        rdata = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [31:0] d);
        apb(1'b1, addr, d);
    endtask : wr

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rdata, exp, "register read");
    endtask : rd_chk

    initial begin
        #40000;
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        reset = 1'b1;
        apb_req = '0;
        periph_out = '0;
        periph_oe = '0;
        shutdown_mode = 1'b0;
        opt_reset = 1'b0;
        board_val = '0;
        tick(20);
        reset <= 1'b0;
        @(posedge clock);
        rd_chk(pmx_pkg::ADDR_SLOT_SEL, pmx_pkg::SLOT_SEL_RESET);
        rd_chk(pmx_pkg::ADDR_PULL_UP, 32'h0000_00c0);
        check({24'h0, pin_drive.pull_up}, {24'h0, pmx_pkg::PULL_UP_RESET}, "pull-up after reset");
        rd_chk(pmx_pkg::ADDR_GPIO_OE, 32'h0);
        check({24'h0, pin_drive.oe}, 32'h0, "oe after reset");
        apb(1'b0, 12'hffc, 32'h0);
        check({rdata[30:0], rerr}, 32'h1, "unmapped access");
        for (int f = 1; f < 14; f++) begin
            sel = '0;
            used = '0;
            ws = 99;
            for (int p = 0; p < 8; p++) begin
                sl = 0;
                for (int s = 7; s >= 1; s--) begin
                    if (pmx_pkg::SLOT_MAP[p][s] == f)
                        sl = s;
                end
                if (sl != 0) begin
                    sel[4*p +: 4] = sl[3:0];
                    used[p] = 1'b1;
                    if (sl < ws) begin
                        win = p;
                        ws = sl;
                    end
                end
            end
            wr(pmx_pkg::ADDR_SLOT_SEL, sel);
            periph_oe <= 16'h1 << f;
            periph_out <= 16'h1 << f;
            tick(3);
            check({16'h0, pin_drive.oe & used, pin_drive.out & used}, {16'h0, used, used}, "shared out");
            periph_out <= '0;
            tick(3);
            check({24'h0, pin_drive.out & used}, 32'h0, "shared out low");
            periph_oe <= '0;
            board_val <= 8'h01 << win;
            tick(3);
            check({31'h0, periph_in[f]}, 32'h1, "input from winner");
            board_val <= used & ~(8'h01 << win);
            tick(3);
            check({31'h0, periph_in[f]}, 32'h0, "losers ignored");
        end
        wr(pmx_pkg::ADDR_SLOT_SEL, 32'h0008_0800);
        wr(pmx_pkg::ADDR_REMAP, 32'h0006_0500);
        periph_oe <= 16'h0060;
        periph_out <= 16'h0020;
        tick(3);
        check({16'h0, pin_drive.oe & 8'h14, pin_drive.out & 8'h14}, 32'h1404, "remap out");
        wr(pmx_pkg::ADDR_SLOT_SEL, 32'h0);
        periph_oe <= '0;
        board_val <= '0;
        wr(pmx_pkg::ADDR_IRQ_RISE, 32'h08);
        wr(pmx_pkg::ADDR_INT_MASK, 32'h08);
        board_val <= 8'h08;
        tick(3);
        check({31'h0, irq}, 32'h1, "irq raised");
        rd_chk(pmx_pkg::ADDR_INT_STATUS, 32'h08);
        wr(pmx_pkg::ADDR_INT_MASK, 32'h0);
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(pmx_pkg::ADDR_INT_STATUS, 32'h08);
        rd_chk(pmx_pkg::ADDR_INT_STATUS, 32'h0);
        wr(pmx_pkg::ADDR_IRQ_FALL, 32'h08);
        board_val <= 8'h00;
        tick(3);
        rd_chk(pmx_pkg::ADDR_INT_STATUS, 32'h08);
        wr(pmx_pkg::ADDR_GPIO_OUT, 32'hff);
        wr(pmx_pkg::ADDR_GPIO_OE, 32'h9e);
        wr(pmx_pkg::ADDR_WAKE_EN, 32'h01);
        wr(pmx_pkg::ADDR_INT_MASK, 32'h100);
        shutdown_mode <= 1'b1;
        tick(3);
        wr(pmx_pkg::ADDR_GPIO_OUT, 32'h0);
        check({16'h0, pin_drive.oe & 8'h9e, pin_drive.out & 8'h9e}, 32'h9e9e, "retention");
        board_val <= 8'h09;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wake_request !== 1'b1 && n < 10);
        check({31'h0, wake_request}, 32'h1, "wake pulse");
        check({31'h0, irq}, 32'h1, "wake irq");
        rd_chk(pmx_pkg::ADDR_INT_STATUS, 32'h108);
        rd_chk(pmx_pkg::ADDR_GPIO_IN, 32'h9f);
        rd_chk(pmx_pkg::ADDR_STATE, 32'h1);
        shutdown_mode <= 1'b0;
        tick(3);
        check({24'h0, pin_drive.out & 8'h9e}, 32'h0, "live after exit");
        wr(pmx_pkg::ADDR_GPIO_OE, 32'hff);
        opt_reset <= 1'b1;
        board_val <= 8'h00;
        tick(3);
        check({30'h0, pin_drive.oe[5], ext_req}, 32'h1, "pin as reset low");
        board_val <= 8'h20;
        tick(3);
        check({30'h0, pin_drive.oe[5], ext_req}, 32'h0, "pin as reset high");
        opt_reset <= 1'b0;
        tick(3);
        check({30'h0, pin_drive.oe[5], ext_req}, 32'h2, "pin as io");
        results();
    end
endmodule : tb

// ===== verilog/pmx_pin_cell.sv
module pmx_pin_cell (
    input  wire logic [pmx_pkg::SLOT_W-1:0]                     slot,
    input  wire pmx_pkg::pmx_func_type [pmx_pkg::NUM_SLOTS-1:0] slot_row,
    input  wire pmx_pkg::pmx_func_type                          remap_func,
    input  wire logic                                           gpio_out,
    input  wire logic                                           gpio_oe,
    input  wire logic [pmx_pkg::NUM_FUNCS-1:0]                  periph_out,
    input  wire logic [pmx_pkg::NUM_FUNCS-1:0]                  periph_oe,
    output pmx_pkg::pmx_func_type                               func,
    output logic                                                out,
    output logic                                                oe
);

    always_comb begin
        func = pmx_pkg::FUNC_NONE;
        if (slot == pmx_pkg::REDEF_SLOT) begin
            func = remap_func;
        end else if (slot < pmx_pkg::REDEF_SLOT) begin
            func = slot_row[slot[2:0]];
        end
        if (func == pmx_pkg::FUNC_NONE) begin
            out = gpio_out;
            oe  = gpio_oe;
        end else begin
            out = periph_out[func];
            oe  = periph_oe[func];
        end
    end

endmodule : pmx_pin_cell

// ===== verilog/pmx_pkg.sv
package pmx_pkg;

    localparam int NUM_PINS  = 8;
    localparam int NUM_SLOTS = 9;
    localparam int NUM_FUNCS = 16;
    localparam int FUNC_W    = 4;
    localparam int SLOT_W    = 4;
    localparam int STAT_W    = 9;

    typedef logic [FUNC_W-1:0] pmx_func_type;
    typedef logic [SLOT_W-1:0] pmx_slot_type;

    // Redefinition slot takes its function from the remap register
    localparam pmx_slot_type REDEF_SLOT = 4'h8;
    localparam pmx_func_type FUNC_NONE  = 4'h0;
    localparam pmx_func_type FUNC_SWDIO = 4'he;
    localparam pmx_func_type FUNC_SWCLK = 4'hf;

    // Function carried by each pin in each slot, [pin][slot]; slot 0 is general IO
    localparam pmx_func_type [NUM_PINS-1:0][NUM_SLOTS-1:0] SLOT_MAP = '{
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h7, 4'h3, FUNC_SWCLK, 4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h2, FUNC_SWDIO, 4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'hd, 4'h6, 4'h1, 4'h9,       4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'hc, 4'h5,       4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'hb, 4'h2, 4'ha,       4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h8, 4'h4,       4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h9, 4'h5, 4'hd, 4'h3,       4'h0},
        '{4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h2, 4'h4, 4'h1,       4'h0}
    };

    localparam int           RESET_SHARED_PIN = 5;
    localparam logic [7:0]   WAKE_CAPABLE_MASK     = 8'h61;
    localparam logic [7:0]   SHUTDOWN_RETENTION_MASK = 8'h9e;

    // Register byte addresses
    localparam logic [11:0] ADDR_SLOT_SEL   = 12'h000;
    localparam logic [11:0] ADDR_GPIO_OUT   = 12'h004;
    localparam logic [11:0] ADDR_GPIO_OE    = 12'h008;
    localparam logic [11:0] ADDR_GPIO_IN    = 12'h00c;
    localparam logic [11:0] ADDR_PULL_UP    = 12'h010;
    localparam logic [11:0] ADDR_REMAP      = 12'h014;
    localparam logic [11:0] ADDR_IRQ_RISE   = 12'h018;
    localparam logic [11:0] ADDR_IRQ_FALL   = 12'h01c;
    localparam logic [11:0] ADDR_WAKE_EN    = 12'h020;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h024;
    localparam logic [11:0] ADDR_INT_MASK   = 12'h028;
    localparam logic [11:0] ADDR_STATE      = 12'h02c;

    // Status bit positions
    localparam int STAT_WAKE_BIT  = 8;
    localparam int STATE_SHUT_BIT = 0;
    localparam int STATE_OPT_BIT  = 1;
    localparam int STATE_RST_BIT  = 2;

    // Reset values: debug pins on slot 1 with pull-up, others general IO, driver off
    localparam logic [31:0] SLOT_SEL_RESET = 32'h1100_0000;
    localparam logic [7:0]  PULL_UP_RESET  = 8'hc0;
    localparam logic [7:0]  GPIO_OE_RESET  = 8'h00;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } pmx_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pmx_apb_rsp_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] pull_up;
    } pmx_pin_drive_type;

endpackage : pmx_pkg

// ===== verilog/pmx_top.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
module pmx_top (
    input  wire logic                             clock,
    input  wire logic                             reset,
    input  wire pmx_pkg::pmx_apb_req_type         apb_req,
    output pmx_pkg::pmx_apb_rsp_type              apb_rsp,
    input  wire logic [pmx_pkg::NUM_PINS-1:0]     pin_in,
    output pmx_pkg::pmx_pin_drive_type            pin_drive,
    input  wire logic [pmx_pkg::NUM_FUNCS-1:0]    periph_out,
    input  wire logic [pmx_pkg::NUM_FUNCS-1:0]    periph_oe,
    output logic [pmx_pkg::NUM_FUNCS-1:0]         periph_in,
    input  wire logic                             shutdown_mode,
    input  wire logic                             opt_reset_pin_is_reset,
    output logic                                  external_reset_input_req,
    output logic                                  wake_request,
    output logic                                  irq
);

    typedef struct packed {
        logic [31:0]                     slot_sel;
        logic [7:0]                      gpio_out;
        logic [7:0]                      gpio_oe;
        logic [7:0]                      pull_up;
        logic [31:0]                     remap;
        logic [7:0]                      irq_rise;
        logic [7:0]                      irq_fall;
        logic [7:0]                      wake_en;
        logic [pmx_pkg::STAT_W-1:0]      status;
        logic [pmx_pkg::STAT_W-1:0]      mask;
        logic [7:0]                      pin_prev;
        logic [7:0]                      hold_out;
        logic [7:0]                      hold_oe;
        logic [7:0]                      out;
        logic [7:0]                      oe;
        logic                            shut_prev;
        logic                            irq;
        logic                            wake;
        logic                            ext_rst;
        logic                            pready;
        logic                            pslverr;
        logic [31:0]                     prdata;
        logic [pmx_pkg::NUM_FUNCS-1:0]   periph_in;
    } pmx_state_type;

    localparam pmx_state_type STATE_RESET = '{
        slot_sel:  pmx_pkg::SLOT_SEL_RESET,
        gpio_oe:   pmx_pkg::GPIO_OE_RESET,
        pull_up:   pmx_pkg::PULL_UP_RESET,
        default:   '0
    };

    pmx_state_type s_reg;
    pmx_state_type s_next;

    pmx_pkg::pmx_func_type      cell_func [pmx_pkg::NUM_PINS];
    logic [pmx_pkg::NUM_PINS-1:0] cell_out;
    logic [pmx_pkg::NUM_PINS-1:0] cell_oe;

    genvar gp;
    generate
        for (gp = 0; gp < pmx_pkg::NUM_PINS; gp++) begin : g_pin
            pmx_pin_cell u_cell (
                .slot       (s_reg.slot_sel[gp*4 +: 4]),
                .slot_row   (pmx_pkg::SLOT_MAP[gp]),
                .remap_func (s_reg.remap[gp*4 +: 4]),
                .gpio_out   (s_reg.gpio_out[gp]),
                .gpio_oe    (s_reg.gpio_oe[gp]),
                .periph_out (periph_out),
                .periph_oe  (periph_oe),
                .func       (cell_func[gp]),
                .out        (cell_out[gp]),
                .oe         (cell_oe[gp])
            );
        end
    endgenerate

    always_comb begin
        logic [31:0]                rd;
        logic                       hit;
        logic                       wr;
        logic [pmx_pkg::STAT_W-1:0] clr;
        logic [pmx_pkg::STAT_W-1:0] set;
        logic [7:0]                 live_out;
        logic [7:0]                 live_oe;
        logic [7:0]                 rise;
        logic [7:0]                 fall;
        logic [7:0]                 usable;
        logic                       found;
        rd       = '0;
        hit      = 1'b1;
        wr       = 1'b0;
        clr      = '0;
        set      = '0;
        live_out = '0;
        live_oe  = '0;
        rise     = '0;
        fall     = '0;
        usable   = '1;
        found    = 1'b0;
        s_next   = s_reg;
        s_next.pready  = 1'b0;
        s_next.pslverr = 1'b0;
        s_next.wake    = 1'b0;

        // Reset-shared pin is taken away from the mux when it is the reset input
        if (opt_reset_pin_is_reset) begin
            usable[pmx_pkg::RESET_SHARED_PIN] = 1'b0;
        end

        // Register read decode
        unique case (apb_req.paddr)
            pmx_pkg::ADDR_SLOT_SEL:   rd = s_reg.slot_sel;
            pmx_pkg::ADDR_GPIO_OUT:   rd = {24'h000000, s_reg.gpio_out};
            pmx_pkg::ADDR_GPIO_OE:    rd = {24'h000000, s_reg.gpio_oe};
            pmx_pkg::ADDR_GPIO_IN:    rd = {24'h000000, pin_in};
            pmx_pkg::ADDR_PULL_UP:    rd = {24'h000000, s_reg.pull_up};
            pmx_pkg::ADDR_REMAP:      rd = s_reg.remap;
            pmx_pkg::ADDR_IRQ_RISE:   rd = {24'h000000, s_reg.irq_rise};
            pmx_pkg::ADDR_IRQ_FALL:   rd = {24'h000000, s_reg.irq_fall};
            pmx_pkg::ADDR_WAKE_EN:    rd = {24'h000000, s_reg.wake_en};
            pmx_pkg::ADDR_INT_STATUS: rd = {23'h0, s_reg.status};
            pmx_pkg::ADDR_INT_MASK:   rd = {23'h0, s_reg.mask};
            pmx_pkg::ADDR_STATE:      rd = {29'h0, s_reg.ext_rst, opt_reset_pin_is_reset, shutdown_mode};
            default:                  hit = 1'b0;
        endcase

        // Answer one cycle into the access phase
        if (apb_req.psel && apb_req.penable && !s_reg.pready) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = !hit;
            s_next.prdata  = apb_req.pwrite ? 32'h00000000 : rd;
        end

        // Writes take effect on the edge that samples pready high
        wr = apb_req.psel && apb_req.penable && s_reg.pready && apb_req.pwrite;
        if (wr) begin
            unique case (apb_req.paddr)
                pmx_pkg::ADDR_SLOT_SEL:   s_next.slot_sel = apb_req.pwdata;
                pmx_pkg::ADDR_GPIO_OUT:   s_next.gpio_out = apb_req.pwdata[7:0];
                pmx_pkg::ADDR_GPIO_OE:    s_next.gpio_oe  = apb_req.pwdata[7:0];
                pmx_pkg::ADDR_PULL_UP:    s_next.pull_up  = apb_req.pwdata[7:0];
                pmx_pkg::ADDR_REMAP:      s_next.remap    = apb_req.pwdata;
                pmx_pkg::ADDR_IRQ_RISE:   s_next.irq_rise = apb_req.pwdata[7:0];
                pmx_pkg::ADDR_IRQ_FALL:   s_next.irq_fall = apb_req.pwdata[7:0];
                pmx_pkg::ADDR_WAKE_EN:    s_next.wake_en  = apb_req.pwdata[7:0] & pmx_pkg::WAKE_CAPABLE_MASK;
                pmx_pkg::ADDR_INT_STATUS: clr             = apb_req.pwdata[pmx_pkg::STAT_W-1:0];
                pmx_pkg::ADDR_INT_MASK:   s_next.mask     = apb_req.pwdata[pmx_pkg::STAT_W-1:0];
                default:                  clr             = '0;
            endcase
        end

        // Live pin drive from the mux
        for (int p = 0; p < pmx_pkg::NUM_PINS; p++) begin
            live_out[p] = cell_out[p];
            live_oe[p]  = cell_oe[p] && usable[p];
        end

        // Latch the drive on shutdown entry
        if (shutdown_mode && !s_reg.shut_prev) begin
            s_next.hold_out = live_out;
            s_next.hold_oe  = live_oe;
        end
        for (int p = 0; p < pmx_pkg::NUM_PINS; p++) begin
            if (shutdown_mode && pmx_pkg::SHUTDOWN_RETENTION_MASK[p]) begin
                if (!s_reg.shut_prev) begin
                    s_next.out[p] = live_out[p];
                    s_next.oe[p]  = live_oe[p];
                end else begin
                    s_next.out[p] = s_reg.hold_out[p];
                    s_next.oe[p]  = s_reg.hold_oe[p];
                end
            end else begin
                s_next.out[p] = live_out[p];
                s_next.oe[p]  = live_oe[p];
            end
        end

        // Input functions: lowest slot wins, then lowest pin
        for (int k = 1; k < pmx_pkg::NUM_FUNCS; k++) begin
            found = 1'b0;
            s_next.periph_in[k] = 1'b0;
            for (int sl = 0; sl < pmx_pkg::NUM_SLOTS; sl++) begin
                for (int p = 0; p < pmx_pkg::NUM_PINS; p++) begin
                    if (!found && usable[p] && cell_func[p] == pmx_pkg::pmx_func_type'(k)
                        && s_reg.slot_sel[p*4 +: 4] == pmx_pkg::pmx_slot_type'(sl)) begin
                        found = 1'b1;
                        s_next.periph_in[k] = pin_in[p];
                    end
                end
            end
        end
        s_next.periph_in[0] = 1'b0;

        // External interrupt edges on digital pins
        rise = pin_in & ~s_reg.pin_prev;
        fall = ~pin_in & s_reg.pin_prev;
        set[7:0] = ((rise & s_reg.irq_rise) | (fall & s_reg.irq_fall)) & usable;

        // Wake from shutdown on a level change of an enabled wake pin
        if (shutdown_mode && s_reg.shut_prev
            && |((rise | fall) & s_reg.wake_en & pmx_pkg::WAKE_CAPABLE_MASK)) begin
            s_next.wake = 1'b1;
            set[pmx_pkg::STAT_WAKE_BIT] = 1'b1;
        end

        // Set wins over a same-cycle clear
        s_next.status = (s_reg.status & ~clr) | set;
        s_next.irq    = |(s_next.status & s_next.mask);

        s_next.ext_rst   = opt_reset_pin_is_reset && !pin_in[pmx_pkg::RESET_SHARED_PIN];
        s_next.pin_prev  = pin_in;
        s_next.shut_prev = shutdown_mode;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_reg <= STATE_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign apb_rsp.prdata       = s_reg.prdata;
    assign apb_rsp.pready       = s_reg.pready;
    assign apb_rsp.pslverr      = s_reg.pslverr;
    assign pin_drive.out        = s_reg.out;
    assign pin_drive.oe         = s_reg.oe;
    assign pin_drive.pull_up    = s_reg.pull_up;
    assign periph_in            = s_reg.periph_in;
    assign external_reset_input_req = s_reg.ext_rst;
    assign wake_request         = s_reg.wake;
    assign irq                  = s_reg.irq;

endmodule : pmx_top
